//--- logic/esm_host_cmd.sv
// host command interpreter and event source of the experiment state machine
`timescale 1ns/10ps
module esm_host_cmd (
  input wire logic clock,
  input wire logic rst,
  input wire logic runCmd,
  input wire logic stopCmd,
  input wire logic resetCmd,
  input wire logic clearStateCmd,
  input wire logic downloadStateCmd,
  input wire logic [3:0] editState,
  input wire logic editSwEventEnable,
  input wire logic editHostNotifyEnable,
  input wire logic [3:0] editSwTarget,
  input wire logic inputLineTargetSet,
  input wire logic inputLineTargetGet,
  input wire logic [3:0] targetLine,
  input wire logic [3:0] targetState,
  output logic [3:0] targetValue,
  output logic targetValid,
  input wire logic hostTriggerCmd,
  input wire logic timerValuesRequest,
  input wire logic [31:0] timer1In,
  input wire logic [31:0] timer2In,
  output logic timerValuesEvent,
  output logic [31:0] timer1Value,
  output logic [31:0] timer2Value,
  input wire logic serialByteWrite,
  input wire logic [7:0] serialByte,
  output logic serialReady,
  output logic serialTx,
  input wire logic loopbackXyLoad,
  input wire logic [15:0] loopbackX,
  input wire logic [15:0] loopbackY,
  input wire logic [15:0] analogX,
  input wire logic [15:0] analogY,
  input wire logic analogXyRequest,
  output logic analogXyEvent,
  output logic [15:0] xyX,
  output logic [15:0] xyY,
  input wire logic [15:0] pointerX,
  input wire logic [15:0] pointerY,
  input wire logic pointerXyRequest,
  output logic pointerXyEvent,
  output logic [15:0] ptrX,
  output logic [15:0] ptrY,
  input wire logic [15:0] digitalIn,
  output logic [3:0] currentState,
  output logic running,
  output logic transitionEvent,
  output logic inputChangeEvent
);
  // lowest set line wins
  function automatic logic [3:0] first_line(input logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = esm_pkg::LINE_COUNT - 1; i >= 0; i--)
      if (v[i])
        r = 4'(i);
    return r;
  endfunction

  esm_serial_if serLink (); // byte path to transmitter

  logic [15:0] sync1_q, sync2_q, sync3_q; // pin synchroniser
  logic [15:0] lvl_q, lvl_d;              // filtered line levels
  logic [15:0] agree;                     // second and third stages match
  logic [15:0] rise;                      // qualified rising edges
  esm_pkg::esm_run_t run_q, run_d;        // running or idle
  logic [3:0] cur_q, cur_d;               // active state
  logic [15:0] swEn_q, swEn_d;            // host trigger enable per state
  logic [15:0] notify_q, notify_d;        // host notify flag per state
  logic [3:0] swTgt_q [16];               // host trigger target per state
  logic [3:0] swTgt_d [16];
  logic [3:0] lineTgt_q [16];             // next state per input line
  logic [3:0] lineTgt_d [16];
  logic loopOn_q, loopOn_d;               // loopback replaces analog
  logic [15:0] loopX_q, loopX_d, loopY_q, loopY_d;
  logic [3:0] tgtVal_q, tgtVal_d;
  logic tgtValid_q, tgtValid_d;
  logic tmrEv_q, tmrEv_d;
  logic [31:0] tmr1_q, tmr1_d, tmr2_q, tmr2_d;
  logic xyEv_q, xyEv_d, ptEv_q, ptEv_d;
  logic [15:0] xyX_q, xyX_d, xyY_q, xyY_d, ptX_q, ptX_d, ptY_q, ptY_d;
  logic trEv_q, trEv_d, inEv_q, inEv_d;
  logic swFire;                           // host trigger honoured

  assign agree = ~(sync2_q ^ sync3_q);
  assign lvl_d = (sync3_q & agree) | (lvl_q & ~agree);
  assign rise = lvl_d & ~lvl_q;
  assign swFire = hostTriggerCmd && (run_q == esm_pkg::ESM_RUN) && swEn_q[cur_q];

  assign serLink.valid = serialByteWrite && !resetCmd;
  assign serLink.data = serialByte;
  assign serLink.abort = resetCmd;
  assign serialReady = serLink.ready;

  esm_serial_tx uTx (
    .clock(clock),
    .rst(rst),
    .link(serLink),
    .serialTx(serialTx)
  );

  // next values of run control, state table and replies
  always_comb
  begin
    run_d = run_q;
    cur_d = cur_q;
    swEn_d = swEn_q;
    notify_d = notify_q;
    swTgt_d = swTgt_q;
    lineTgt_d = lineTgt_q;
    loopOn_d = loopOn_q;
    loopX_d = loopX_q;
    loopY_d = loopY_q;
    tgtVal_d = tgtVal_q;
    tgtValid_d = 1'b0;
    tmrEv_d = 1'b0;
    tmr1_d = tmr1_q;
    tmr2_d = tmr2_q;
    xyEv_d = 1'b0;
    xyX_d = xyX_q;
    xyY_d = xyY_q;
    ptEv_d = 1'b0;
    ptX_d = ptX_q;
    ptY_d = ptY_q;
    trEv_d = 1'b0;
    inEv_d = 1'b0;
    // run control and transitions
    if (stopCmd)
    begin
      run_d = esm_pkg::ESM_IDLE;
      cur_d = esm_pkg::INIT_STATE;
    end
    else if (run_q == esm_pkg::ESM_RUN)
    begin
      if (swFire)
      begin
        cur_d = swTgt_q[cur_q];
        trEv_d = notify_q[swTgt_q[cur_q]];
      end
      else if (rise != 16'h0000)
      begin
        cur_d = lineTgt_q[first_line(rise)];
        trEv_d = notify_q[cur_d];
        inEv_d = notify_q[cur_d];
      end
    end
    else if (runCmd)
      run_d = esm_pkg::ESM_RUN;
    // editing of the state table
    if (clearStateCmd)
    begin
      swEn_d[editState] = esm_pkg::DEF_SW_ENABLE;
      notify_d[editState] = esm_pkg::DEF_NOTIFY;
      swTgt_d[editState] = esm_pkg::DEF_SW_TARGET;
    end
    if (downloadStateCmd)
    begin
      // edits become visible only here
      swEn_d[editState] = editSwEventEnable;
      notify_d[editState] = editHostNotifyEnable;
      swTgt_d[editState] = editSwTarget;
    end
    if (inputLineTargetSet)
      lineTgt_d[targetLine] = targetState;
    if (inputLineTargetGet)
    begin
      tgtVal_d = lineTgt_q[targetLine];
      tgtValid_d = 1'b1;
    end
    // split timer read
    if (timerValuesRequest)
    begin
      tmr1_d = timer1In;
      tmr2_d = timer2In;
      tmrEv_d = 1'b1;
    end
    if (loopbackXyLoad)
    begin
      loopOn_d = 1'b1;
      loopX_d = loopbackX;
      loopY_d = loopbackY;
    end
    if (analogXyRequest)
    begin
      xyX_d = loopOn_q ? loopX_q : analogX;
      xyY_d = loopOn_q ? loopY_q : analogY;
      xyEv_d = 1'b1;
    end
    if (pointerXyRequest)
    begin
      ptX_d = pointerX;
      ptY_d = pointerY;
      ptEv_d = 1'b1;
    end
    // soft reset overrides run control, state table, line targets and loopback
    if (resetCmd)
    begin
      run_d = esm_pkg::ESM_IDLE;
      cur_d = esm_pkg::INIT_STATE;
      swEn_d = {16{esm_pkg::DEF_SW_ENABLE}};
      notify_d = {16{esm_pkg::DEF_NOTIFY}};
      for (int i = 0; i < esm_pkg::STATE_COUNT; i++)
      begin
        swTgt_d[i] = esm_pkg::DEF_SW_TARGET;
        lineTgt_d[i] = esm_pkg::DEF_LINE_TARGET;
      end
      loopOn_d = 1'b0;
      trEv_d = 1'b0;
      inEv_d = 1'b0;
    end
  end

  // register synchroniser, table and replies
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sync1_q <= 16'h0000;
      sync2_q <= 16'h0000;
      sync3_q <= 16'h0000;
      lvl_q <= 16'h0000;
      run_q <= esm_pkg::ESM_IDLE;
      cur_q <= esm_pkg::INIT_STATE;
      swEn_q <= {16{esm_pkg::DEF_SW_ENABLE}};
      notify_q <= {16{esm_pkg::DEF_NOTIFY}};
      for (int i = 0; i < esm_pkg::STATE_COUNT; i++)
      begin
        swTgt_q[i] <= esm_pkg::DEF_SW_TARGET;
        lineTgt_q[i] <= esm_pkg::DEF_LINE_TARGET;
      end
      loopOn_q <= 1'b0;
      {loopX_q, loopY_q, xyX_q, xyY_q, ptX_q, ptY_q} <= 96'h0;
      {tgtVal_q, tgtValid_q, tmrEv_q, xyEv_q, ptEv_q, trEv_q, inEv_q} <= 10'h000;
      {tmr1_q, tmr2_q} <= 64'h0;
    end
    else
    begin
      sync1_q <= digitalIn;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      lvl_q <= lvl_d;
      run_q <= run_d;
      cur_q <= cur_d;
      swEn_q <= swEn_d;
      notify_q <= notify_d;
      swTgt_q <= swTgt_d;
      lineTgt_q <= lineTgt_d;
      loopOn_q <= loopOn_d;
      {loopX_q, loopY_q, xyX_q, xyY_q, ptX_q, ptY_q} <=
        {loopX_d, loopY_d, xyX_d, xyY_d, ptX_d, ptY_d};
      {tgtVal_q, tgtValid_q, tmrEv_q, xyEv_q, ptEv_q, trEv_q, inEv_q} <=
        {tgtVal_d, tgtValid_d, tmrEv_d, xyEv_d, ptEv_d, trEv_d, inEv_d};
      {tmr1_q, tmr2_q} <= {tmr1_d, tmr2_d};
    end
  end

  assign targetValue = tgtVal_q;
  assign targetValid = tgtValid_q;
  assign timerValuesEvent = tmrEv_q;
  assign timer1Value = tmr1_q;
  assign timer2Value = tmr2_q;
  assign analogXyEvent = xyEv_q;
  assign xyX = xyX_q;
  assign xyY = xyY_q;
  assign pointerXyEvent = ptEv_q;
  assign ptrX = ptX_q;
  assign ptrY = ptY_q;
  assign currentState = cur_q;
  assign running = (run_q == esm_pkg::ESM_RUN);
  assign transitionEvent = trEv_q;
  assign inputChangeEvent = inEv_q;

  // steps used by the checks below
  sequence sStop;
    stopCmd && !resetCmd;
  endsequence
  sequence sLoadThenAsk;
    loopbackXyLoad && !resetCmd ##1 analogXyRequest && !loopbackXyLoad && !resetCmd;
  endsequence

  a_stop_initial: assert property (@(posedge clock) disable iff (rst)
    sStop |=> !running && currentState == esm_pkg::INIT_STATE)
    else $error("stop did not return to initial state");
  a_run_start: assert property (@(posedge clock) disable iff (rst)
    runCmd && !stopCmd && !resetCmd && !running |=> running [*1])
    else $error("run did not start");
  a_soft_reset: assert property (@(posedge clock) disable iff (rst)
    resetCmd |=> !running && swEn_q == 16'h0000 && notify_q == 16'h0000 && !loopOn_q)
    else $error("soft reset left state behind");
  a_trigger_gate: assert property (@(posedge clock) disable iff (rst)
    hostTriggerCmd && !swEn_q[cur_q] && rise == 16'h0000 && !stopCmd && !resetCmd
    |=> $stable(cur_q))
    else $error("disabled host trigger moved state");
  a_trigger_move: assert property (@(posedge clock) disable iff (rst)
    hostTriggerCmd && running && swEn_q[cur_q] && !stopCmd && !resetCmd
    |=> cur_q == $past(swTgt_q[cur_q]))
    else $error("host trigger went to wrong state");
  a_line_target: assert property (@(posedge clock) disable iff (rst)
    running && rise == 16'h0080 && !swFire && !stopCmd && !resetCmd
    |=> cur_q == $past(lineTgt_q[7]))
    else $error("input line went to wrong state");
  a_notify_gate: assert property (@(posedge clock) disable iff (rst)
    transitionEvent |-> notify_q[cur_q] || $past(resetCmd) || $past(downloadStateCmd)
    || $past(clearStateCmd))
    else $error("transition reported for quiet state");
  a_clear_state: assert property (@(posedge clock) disable iff (rst)
    clearStateCmd && !downloadStateCmd && !resetCmd
    |=> !swEn_q[$past(editState)] && !notify_q[$past(editState)])
    else $error("clear left state properties set");
  a_timer_reply: assert property (@(posedge clock) disable iff (rst)
    timerValuesRequest |=> timerValuesEvent && timer1Value == $past(timer1In)
    && timer2Value == $past(timer2In))
    else $error("timer reply missing or wrong");
  a_loopback_used: assert property (@(posedge clock) disable iff (rst)
    sLoadThenAsk |=> xyX == $past(loopbackX, 2) && xyY == $past(loopbackY, 2))
    else $error("loopback data not used");
  a_xy_event: assert property (@(posedge clock) disable iff (rst)
    analogXyRequest && !loopOn_q |=> analogXyEvent && xyX == $past(analogX))
    else $error("analog data reply missing");
  a_pointer_event: assert property (@(posedge clock) disable iff (rst)
    pointerXyRequest |=> pointerXyEvent ##1 !pointerXyEvent || $past(pointerXyRequest))
    else $error("pointer data reply wrong");
endmodule

//--- logic/esm_pkg.sv
// constants shared by the experiment state machine command block
//
// Contract
// - each input line holds own next-state target
// - host trigger moves only if state enables
// - run starts; stop halts, returns to initial
// - reset command soft-resets run control, state table, line targets, loopback and transmitter
// - clear-state restores edited state to defaults
// - timer request answered later by timer event
// - transition reported only if new state notifies
// - serial write while transmitter ready sends exactly one byte
// - loopback XY replaces analog inputs when loaded
// - analog XY request returns data with event
// - pointer XY request returns data with event
package esm_pkg;
  localparam int unsigned STATE_COUNT = 16;      // states held in the table
  localparam int unsigned STATE_W = 4;           // state index width
  localparam int unsigned LINE_COUNT = 16;       // digital input lines
  localparam int unsigned TIMER_W = 32;          // global timer width
  localparam int unsigned XY_W = 16;             // one XY coordinate
  localparam logic [3:0] INIT_STATE = 4'h0;      // state after stop or reset
  localparam logic DEF_SW_ENABLE = 1'b0;         // default host trigger enable
  localparam logic DEF_NOTIFY = 1'b0;            // default host notify flag
  localparam logic [3:0] DEF_SW_TARGET = 4'h0;   // default host trigger target
  localparam logic [3:0] DEF_LINE_TARGET = 4'h0; // line target after reset
  localparam int unsigned CLOCK_HZ = 200000000;  // system clock rate
  localparam int unsigned BAUD_RATE = 115200;    // serial bit rate
  localparam int unsigned BIT_CYCLES = CLOCK_HZ / BAUD_RATE; // rounded down
  localparam int unsigned FRAME_BITS = 10;       // start, 8 data, stop
  // run control state
  typedef enum logic [0:0] {
    ESM_IDLE = 1'b0,
    ESM_RUN = 1'b1
  } esm_run_t;
  // serial transmitter state
  typedef enum logic [0:0] {
    ESM_TX_IDLE = 1'b0,
    ESM_TX_SEND = 1'b1
  } esm_tx_t;
endpackage

//--- logic/esm_serial_if.sv
// byte hand-off between the command block and its serial transmitter
`timescale 1ns/10ps
interface esm_serial_if;
  logic valid;      // byte offered
  logic [7:0] data; // byte to send
  logic ready;      // transmitter idle
  logic abort;      // soft reset of transmitter
  modport src (output valid, output data, output abort, input ready);
  modport snk (input valid, input data, input abort, output ready);
endinterface

//--- logic/esm_serial_tx.sv
// asynchronous serial transmitter, one byte per accepted request
`timescale 1ns/10ps
module esm_serial_tx (
  input wire logic clock,
  input wire logic rst,
  esm_serial_if.snk link,
  output logic serialTx
);
  esm_pkg::esm_tx_t state_q, state_d; // idle or sending
  logic [9:0] shift_q, shift_d;       // frame being shifted out
  logic [3:0] bits_q, bits_d;         // bits left in frame
  logic [15:0] cnt_q, cnt_d;          // cycles left in bit
  logic tx_q, tx_d;                   // line level

  assign link.ready = (state_q == esm_pkg::ESM_TX_IDLE);
  assign serialTx = tx_q;

  // next values of the transmitter
  always_comb
  begin
    state_d = state_q;
    shift_d = shift_q;
    bits_d = bits_q;
    cnt_d = cnt_q;
    tx_d = tx_q;
    if (link.abort)
    begin
      state_d = esm_pkg::ESM_TX_IDLE;
      tx_d = 1'b1;
    end
    else
    begin
      unique case (state_q)
        esm_pkg::ESM_TX_IDLE:
        begin
          if (link.valid)
          begin
            // one frame per request
            shift_d = {1'b1, link.data, 1'b0};
            bits_d = 4'(esm_pkg::FRAME_BITS);
            cnt_d = 16'h0000;
            state_d = esm_pkg::ESM_TX_SEND;
          end
        end
        esm_pkg::ESM_TX_SEND:
        begin
          if (cnt_q == 16'h0000)
          begin
            // start next bit or finish frame
            if (bits_q == 4'h0)
            begin
              state_d = esm_pkg::ESM_TX_IDLE;
              tx_d = 1'b1;
            end
            else
            begin
              tx_d = shift_q[0];
              shift_d = {1'b1, shift_q[9:1]};
              bits_d = bits_q - 4'h1;
              cnt_d = 16'(esm_pkg::BIT_CYCLES - 1);
            end
          end
          else
          begin
            cnt_d = cnt_q - 16'h0001;
          end
        end
      endcase
    end
  end

  // register the transmitter
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_q <= esm_pkg::ESM_TX_IDLE;
      shift_q <= 10'h3ff;
      bits_q <= 4'h0;
      cnt_q <= 16'h0000;
      tx_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      shift_q <= shift_d;
      bits_q <= bits_d;
      cnt_q <= cnt_d;
      tx_q <= tx_d;
    end
  end

  // an accepted byte leaves idle at once
  a_tx_accept: assert property (@(posedge clock) disable iff (rst)
    link.valid && link.ready && !link.abort |=> !link.ready)
    else $error("transmitter did not take byte");
endmodule

//--- verif/esm_host_cmd_tb.sv
// self-checking bench of the host command block
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin samplesChecked++; if ((got) !== (ex)) begin errorCnt++; \
  $display("mismatch %s exp %h got %h", nm, ex, got); end end
module esm_host_cmd_tb;
  logic clock, rst, runCmd, stopCmd, resetCmd, clearStateCmd, downloadStateCmd;
  logic [3:0] editState, editSwTarget, targetLine, targetState, targetValue, currentState;
  logic editSwEventEnable, editHostNotifyEnable, inputLineTargetSet, inputLineTargetGet;
  logic targetValid, hostTriggerCmd, timerValuesRequest, timerValuesEvent;
  logic [31:0] timer1In, timer2In, timer1Value, timer2Value;
  logic serialByteWrite, serialReady, serialTx, loopbackXyLoad, analogXyRequest;
  logic [7:0] serialByte, rxByte;
  logic [15:0] loopbackX, loopbackY, analogX, analogY, xyX, xyY;
  logic [15:0] pointerX, pointerY, ptrX, ptrY, digitalIn;
  logic analogXyEvent, pointerXyRequest, pointerXyEvent, running;
  logic transitionEvent, inputChangeEvent;
  int rxCount; // bytes the receiver model got
  int errorCnt = 0; // mismatches
  int samplesChecked = 0; // comparisons
  logic [3:0] lineTgt [16]; // expected line targets
  logic swEn [16]; // expected trigger enables
  logic notify [16]; // expected notify flags
  logic [3:0] swTgt [16]; // expected trigger targets
  logic loopOn; // loopback loaded
  esm_host_cmd esm_host_cmd_inst (.clock(clock), .rst(rst), .runCmd(runCmd), .stopCmd(stopCmd),
    .resetCmd(resetCmd), .clearStateCmd(clearStateCmd), .downloadStateCmd(downloadStateCmd),
    .editState(editState), .editSwEventEnable(editSwEventEnable),
    .editHostNotifyEnable(editHostNotifyEnable), .editSwTarget(editSwTarget),
    .inputLineTargetSet(inputLineTargetSet), .inputLineTargetGet(inputLineTargetGet),
    .targetLine(targetLine), .targetState(targetState), .targetValue(targetValue),
    .targetValid(targetValid), .hostTriggerCmd(hostTriggerCmd),
    .timerValuesRequest(timerValuesRequest), .timer1In(timer1In), .timer2In(timer2In),
    .timerValuesEvent(timerValuesEvent), .timer1Value(timer1Value), .timer2Value(timer2Value),
    .serialByteWrite(serialByteWrite), .serialByte(serialByte), .serialReady(serialReady),
    .serialTx(serialTx), .loopbackXyLoad(loopbackXyLoad), .loopbackX(loopbackX),
    .loopbackY(loopbackY), .analogX(analogX), .analogY(analogY),
    .analogXyRequest(analogXyRequest), .analogXyEvent(analogXyEvent), .xyX(xyX), .xyY(xyY),
    .pointerX(pointerX), .pointerY(pointerY), .pointerXyRequest(pointerXyRequest),
    .pointerXyEvent(pointerXyEvent), .ptrX(ptrX), .ptrY(ptrY), .digitalIn(digitalIn),
    .currentState(currentState), .running(running), .transitionEvent(transitionEvent),
    .inputChangeEvent(inputChangeEvent));
  esm_uart_rx_model esm_uart_rx_model_inst (.clock(clock), .serialTx(serialTx),
    .rxByte(rxByte), .rxCount(rxCount));
  // 200 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // state the trigger should lead to
  function automatic logic [3:0] expTrig(input logic [3:0] cur);
    return swEn[cur] ? swTgt[cur] : cur;
  endfunction
  // one-cycle pulse on falling edges, a low cycle between back-to-back pulses
  task automatic pulse(ref logic s);
    @(negedge clock);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
  endtask
  // write one line target
  task automatic setTarget(input logic [3:0] ln, input logic [3:0] st);
    targetLine = ln;
    targetState = st;
    pulse(inputLineTargetSet);
  endtask
  // read one line target and compare
  task automatic getTarget(input logic [3:0] ln, input logic [3:0] ex);
    targetLine = ln;
    pulse(inputLineTargetGet);
    `CHK("targetValid", 1'b1, targetValid)
    `CHK("targetValue", ex, targetValue)
  endtask
  // download one state definition
  task automatic download(input logic [3:0] st, input logic en, input logic nt,
    input logic [3:0] tg);
    editState = st;
    editSwEventEnable = en;
    editHostNotifyEnable = nt;
    editSwTarget = tg;
    swEn[st] = en;
    notify[st] = nt;
    swTgt[st] = tg;
    pulse(downloadStateCmd);
  endtask
  // host trigger and its outcome
  task automatic trigger();
    logic [3:0] ex;
    logic fire;
    fire = running && swEn[currentState];
    ex = running ? expTrig(currentState) : currentState;
    pulse(hostTriggerCmd);
    `CHK("trigState", ex, currentState)
    `CHK("trigEvent", fire & notify[ex], transitionEvent)
  endtask
  // print counts and verdict
  task automatic testDone();
    $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // hang guard
  initial
  begin
    repeat (90000) @(posedge clock);
    errorCnt++;
    testDone();
  end
  // main sequence
  initial
  begin
    {runCmd, stopCmd, resetCmd, clearStateCmd, downloadStateCmd, hostTriggerCmd} = '0;
    {inputLineTargetSet, inputLineTargetGet, timerValuesRequest, serialByteWrite} = '0;
    {loopbackXyLoad, analogXyRequest, pointerXyRequest, editSwEventEnable} = '0;
    {editHostNotifyEnable, editState, editSwTarget, targetLine, targetState} = '0;
    {timer1In, timer2In, serialByte, loopbackX, loopbackY, analogX, analogY} = '0;
    {pointerX, pointerY, digitalIn} = '0;
    loopOn = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      swEn[i] = esm_pkg::DEF_SW_ENABLE;
      notify[i] = esm_pkg::DEF_NOTIFY;
      swTgt[i] = esm_pkg::DEF_SW_TARGET;
    end
    rst = 1'b1;
    void'($urandom(48938));
    repeat (2) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    `CHK("serialTx", 1'b1, serialTx)
    `CHK("running", 1'b0, running)
    // independent target per line, line 7 forced to 5
    for (int i = 0; i < 16; i++)
    begin
      lineTgt[i] = (i == 7) ? 4'h5 : 4'($urandom);
      setTarget(4'(i), lineTgt[i]);
    end
    for (int i = 15; i >= 0; i--)
      getTarget(4'(i), lineTgt[i]);
    download(4'h0, 1'b1, 1'b0, 4'h5);
    download(4'h5, 1'b1, 1'b1, 4'h3);
    download(4'h3, 1'b0, 1'b0, 4'h9);
    // local edit of state 3 without download must stay unseen
    editSwEventEnable = 1'b1;
    editHostNotifyEnable = 1'b1;
    pulse(runCmd);
    `CHK("running", 1'b1, running)
    repeat (3) trigger();
    digitalIn[7] = 1'b1;
    for (int n = 0; n < 20 && inputChangeEvent !== 1'b1; n++)
      @(negedge clock);
    `CHK("lineEvent", 1'b1, inputChangeEvent)
    `CHK("lineState", lineTgt[7], currentState)
    pulse(stopCmd);
    `CHK("stopRun", 1'b0, running)
    `CHK("stopState", esm_pkg::INIT_STATE, currentState)
    digitalIn = '0;
    trigger();
    // clear state 0 back to defaults
    editState = 4'h0;
    pulse(clearStateCmd);
    swEn[0] = esm_pkg::DEF_SW_ENABLE;
    notify[0] = esm_pkg::DEF_NOTIFY;
    pulse(runCmd);
    trigger();
    pulse(stopCmd);
    // split replies, loopback loaded halfway
    for (int i = 0; i < 6; i++)
    begin
      {timer1In, timer2In} = {$urandom, $urandom};
      {analogX, analogY, pointerX, pointerY} = {$urandom, $urandom};
      if (i == 3)
      begin
        // loaded once, so later rounds expect these same values
        {loopbackX, loopbackY} = $urandom;
        pulse(loopbackXyLoad);
        loopOn = 1'b1;
      end
      timerValuesRequest = 1'b1;
      analogXyRequest = 1'b1;
      pointerXyRequest = 1'b1;
      @(negedge clock);
      {timerValuesRequest, analogXyRequest, pointerXyRequest} = '0;
      `CHK("timerEvent", 1'b1, timerValuesEvent)
      `CHK("timers", {timer1In, timer2In}, {timer1Value, timer2Value})
      `CHK("xyEvent", 1'b1, analogXyEvent)
      `CHK("xy", loopOn ? {loopbackX, loopbackY} : {analogX, analogY}, {xyX, xyY})
      `CHK("ptrEvent", 1'b1, pointerXyEvent)
      `CHK("ptr", {pointerX, pointerY}, {ptrX, ptrY})
      @(negedge clock);
      `CHK("timerPulse", 1'b0, timerValuesEvent)
    end
    // one byte out, second write while busy is dropped
    serialByte = 8'($urandom);
    pulse(serialByteWrite);
    `CHK("busy", 1'b0, serialReady)
    begin
      logic [7:0] sent;
      sent = serialByte;
      serialByte = ~sent;
      pulse(serialByteWrite);
      for (int n = 0; n < 20000 && serialReady !== 1'b1; n++)
        @(negedge clock);
      repeat (esm_pkg::BIT_CYCLES * 11) @(negedge clock);
      `CHK("rxCount", 1, rxCount)
      `CHK("rxByte", sent, rxByte)
    end
    // soft reset from the running state, cutting a frame in flight
    serialByte = 8'h00;
    pulse(serialByteWrite);
    repeat (esm_pkg::BIT_CYCLES * 2) @(negedge clock);
    `CHK("frameLow", 1'b0, serialTx)
    pulse(runCmd);
    pulse(resetCmd);
    @(negedge clock);
    `CHK("rstRun", 1'b0, running)
    `CHK("rstState", esm_pkg::INIT_STATE, currentState)
    `CHK("abortReady", 1'b1, serialReady)
    `CHK("abortTx", 1'b1, serialTx)
    getTarget(4'h7, esm_pkg::DEF_LINE_TARGET);
    testDone();
  end
endmodule

//--- verif/esm_uart_rx_model.sv
// serial receiver model standing at the far end of the serial line
`timescale 1ns/10ps
module esm_uart_rx_model (
  input wire logic clock,
  input wire logic serialTx,
  output logic [7:0] rxByte,
  output int rxCount
);
  logic [7:0] shiftReg; // bits gathered so far
  // receive 8N1 frames, lsb first, sampled mid-bit
  initial
  begin
    rxByte = 8'h00;
    rxCount = 0;
    forever
    begin
      @(negedge serialTx);
      repeat (esm_pkg::BIT_CYCLES / 2) @(posedge clock);
      if (serialTx === 1'b0) // start bit still low
      begin
        for (int i = 0; i < 8; i++)
        begin
          repeat (esm_pkg::BIT_CYCLES) @(posedge clock);
          shiftReg[i] = serialTx;
        end
        repeat (esm_pkg::BIT_CYCLES) @(posedge clock);
        if (serialTx === 1'b1) // stop bit seen
        begin
          rxByte = shiftReg;
          rxCount++;
        end
      end
    end
  end
endmodule
